// ---- bus_host_model.sv ----
`timescale 1ns/100ps
module bus_host_model (
  input wire go,
  output reg sclLine = 1'b1,
  output reg sdaLine = 1'b1
);
  // Pull-ups hold both lines high between frames
  always @(posedge go) begin
    sdaLine = 1'b0;
    #32 sclLine = 1'b0;
    #32 sclLine = 1'b1;
    #32 sdaLine = 1'b1;
  end
endmodule // bus_host_model

// ---- supervisor_watchdog_reset.v ----
`timescale 1ns/100ps
`include "supervisor_watchdog_reset_defines.vh"
module supervisor_watchdog_reset #(
  parameter RESET_ACTIVE_HIGH = 0,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire supplyLowRaw,
  input wire sdaIn,
  input wire sclIn,
  input wire writeProtectIn,
  input wire busTransactionDone,
  input wire busBusy,
  input wire periodWriteReq,
  input wire [1:0] periodWriteData,
  input wire nvWriteReq,
  input wire nvWriteBusy,
  output wire resetOut,
  output wire resetOe,
  output wire busAbort,
  output wire busAcceptEn,
  output wire nvWriteGrant,
  output reg [1:0] watchdogPeriodSel,
  output reg resetActive
);

  localparam ST_POWERUP = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_BROWNOUT = 2'h2;
  localparam ST_WDOG = 2'h3;

  // Tick counts held at full width, then cut to the counter widths on purpose
  localparam [31:0] TICK_FULL = TICK_CYCLES;
  localparam [31:0] PUP_HOLD_FULL = `POWER_UP_HOLD_TICKS;
  localparam [31:0] BO_HOLD_FULL = `BROWNOUT_HOLD_TICKS;
  localparam [31:0] WDOG_00_FULL = `WDOG_00_TICKS;
  localparam [31:0] WDOG_01_FULL = `WDOG_01_TICKS;
  localparam [31:0] WDOG_10_FULL = `WDOG_10_TICKS;
  localparam [`TICK_CNT_W-1:0] TICK_LAST = TICK_FULL[`TICK_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] PUP_HOLD_LAST = PUP_HOLD_FULL[`HOLD_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] BO_HOLD_LAST = BO_HOLD_FULL[`HOLD_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] WDOG_00_LAST = WDOG_00_FULL[`HOLD_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] WDOG_01_LAST = WDOG_01_FULL[`HOLD_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] WDOG_10_LAST = WDOG_10_FULL[`HOLD_CNT_W-1:0] - 1'b1;
  localparam [`HOLD_CNT_W-1:0] CNT_MAX = {`HOLD_CNT_W{1'b1}};

  // Last tick count before the watchdog expires
  function [`HOLD_CNT_W-1:0] wdogLast;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wdogLast = WDOG_00_LAST;
        2'h1: wdogLast = WDOG_01_LAST;
        2'h2: wdogLast = WDOG_10_LAST;
        default: wdogLast = CNT_MAX;
      endcase
    end
  endfunction

  function [`HOLD_CNT_W-1:0] holdLast;
    input [1:0] st;
    begin
      case (st)
        ST_POWERUP: holdLast = PUP_HOLD_LAST;
        default: holdLast = BO_HOLD_LAST;
      endcase
    end
  endfunction

  reg supMeta_q;
  reg supLow_q;
  reg sdaMeta_q;
  reg sda_q;
  reg sdaPrev_q;
  reg sclMeta_q;
  reg scl_q;
  reg sclPrev_q;
  reg wpMeta_q;
  reg wp_q;
  reg [`TICK_CNT_W-1:0] tickCnt_q;
  reg [`TICK_CNT_W-1:0] tickCnt_d;
  reg tick_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`HOLD_CNT_W-1:0] holdCnt_q;
  reg [`HOLD_CNT_W-1:0] holdCnt_d;
  reg [`HOLD_CNT_W-1:0] wdogCnt_q;
  reg [`HOLD_CNT_W-1:0] wdogCnt_d;
  reg abort_q;
  reg abort_d;
  reg inFrame_q;
  wire startCond;
  wire stopCond;
  wire sdaEdge;
  wire wdogOn;
  wire holdDone;
  wire wdogExpired;
  wire wdogRestart;

  // Two-flop synchronisers; first stage read only by second
  always @(posedge clk) begin
    if (!resetn) begin
      supMeta_q <= 1'b1;
      supLow_q <= 1'b1;
    end else begin
      supMeta_q <= supplyLowRaw;
      supLow_q <= supMeta_q;
    end
  end

  // Data line keeps one extra stage for edge detection
  always @(posedge clk) begin
    if (!resetn) begin
      sdaMeta_q <= 1'b1;
      sda_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sdaMeta_q <= sdaIn;
      sda_q <= sdaMeta_q;
      sdaPrev_q <= sda_q;
    end
  end

  // Clock line idles high under its pull-up, so no false edge after reset
  always @(posedge clk) begin
    if (!resetn) begin
      sclMeta_q <= 1'b1;
      scl_q <= 1'b1;
      sclPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= sclIn;
      scl_q <= sclMeta_q;
      sclPrev_q <= scl_q;
    end
  end

  // Write-protect resets low: an unused pin is tied to ground
  always @(posedge clk) begin
    if (!resetn) begin
      wpMeta_q <= 1'b0;
      wp_q <= 1'b0;
    end else begin
      wpMeta_q <= writeProtectIn;
      wp_q <= wpMeta_q;
    end
  end

  assign sdaEdge = sda_q != sdaPrev_q;
  assign startCond = scl_q && sclPrev_q && sdaPrev_q && !sda_q;
  assign stopCond = scl_q && sclPrev_q && !sdaPrev_q && sda_q;
  assign wdogOn = watchdogPeriodSel != `WDOG_SEL_DISABLED;

  // Single timebase shared by every hold and watchdog interval
  always @* begin
    if (tickCnt_q == TICK_LAST) begin
      tickCnt_d = {`TICK_CNT_W{1'b0}};
    end else begin
      tickCnt_d = tickCnt_q + 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      tickCnt_q <= {`TICK_CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      tick_q <= tickCnt_q == TICK_LAST;
    end
  end

  // Tracks a framed transaction, start then stop
  always @(posedge clk) begin
    if (!resetn || supLow_q) begin
      inFrame_q <= 1'b0;
    end else if (startCond) begin
      inFrame_q <= 1'b1;
    end else if (stopCond) begin
      inFrame_q <= 1'b0;
    end
  end

  // Period bits stand in for nonvolatile storage; reset loads the factory code
  always @(posedge clk) begin
    if (!resetn) begin
      watchdogPeriodSel <= `WDOG_SEL_RESET;
    end else if (periodWriteReq && !wp_q && !supLow_q) begin
      watchdogPeriodSel <= periodWriteData;
    end
  end

  assign holdDone = tick_q && holdCnt_q == holdLast(state_q);
  assign wdogExpired = wdogOn && tick_q && wdogCnt_q >= wdogLast(watchdogPeriodSel);

  // Reset sequencer, next state
  always @* begin
    state_d = state_q;
    holdCnt_d = holdCnt_q;
    abort_d = 1'b0;
    case (state_q)
      ST_POWERUP: begin
        if (supLow_q) begin
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end else if (holdDone) begin
          state_d = ST_RUN;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end else if (tick_q) begin
          holdCnt_d = holdCnt_q + 1'b1;
        end
      end
      ST_RUN: begin
        if (supLow_q) begin
          state_d = ST_BROWNOUT;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
          abort_d = 1'b1;
        end else if (wdogExpired) begin
          state_d = ST_WDOG;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end
      end
      ST_BROWNOUT: begin
        // Any dip restarts the full hold; supply must stay good throughout
        if (supLow_q) begin
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end else if (holdDone) begin
          state_d = ST_RUN;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end else if (tick_q) begin
          holdCnt_d = holdCnt_q + 1'b1;
        end
      end
      ST_WDOG: begin
        // Watchdog reset pulse reuses the brownout hold length
        if (supLow_q) begin
          state_d = ST_BROWNOUT;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
          abort_d = 1'b1;
        end else if (holdDone) begin
          state_d = ST_RUN;
          holdCnt_d = {`HOLD_CNT_W{1'b0}};
        end else if (tick_q) begin
          holdCnt_d = holdCnt_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_POWERUP;
        holdCnt_d = {`HOLD_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_POWERUP;
      holdCnt_q <= {`HOLD_CNT_W{1'b0}};
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      holdCnt_q <= holdCnt_d;
      abort_q <= abort_d;
    end
  end

  assign wdogRestart = sdaEdge || busTransactionDone || (inFrame_q && stopCond);

  // Watchdog count; any data edge, framed transaction or reset clears it
  always @* begin
    if (state_q != ST_RUN) begin
      wdogCnt_d = {`HOLD_CNT_W{1'b0}};
    end else if (wdogRestart) begin
      wdogCnt_d = {`HOLD_CNT_W{1'b0}};
    end else if (tick_q && wdogCnt_q != CNT_MAX) begin
      wdogCnt_d = wdogCnt_q + 1'b1;
    end else begin
      wdogCnt_d = wdogCnt_q;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      wdogCnt_q <= {`HOLD_CNT_W{1'b0}};
    end else begin
      wdogCnt_q <= wdogCnt_d;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      resetActive <= 1'b1;
    end else begin
      resetActive <= state_q != ST_RUN;
    end
  end

  // Open drain: pull only when the output level is low
  assign resetOut = 1'b0;
  assign resetOe = RESET_ACTIVE_HIGH ? !resetActive : resetActive;
  assign busAbort = abort_q && busBusy;
  assign busAcceptEn = !supLow_q;
  // A write already running is finished by the engine; only new starts are gated
  assign nvWriteGrant = nvWriteReq && !supLow_q && !wp_q && !nvWriteBusy;

endmodule // supervisor_watchdog_reset

// ---- supervisor_watchdog_reset_defines.vh ----
`ifndef SUPERVISOR_WATCHDOG_RESET_DEFINES_VH
`define SUPERVISOR_WATCHDOG_RESET_DEFINES_VH

`define CLK_FREQ_HZ 125000000
`define TICK_PERIOD_US 100
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)
`define TICKS_PER_MS (1000 / `TICK_PERIOD_US)
`define BROWNOUT_HOLD_MS 200
`define POWER_UP_RESET_HOLD_MS 250
`define WDOG_PERIOD_00_MS 1400
`define WDOG_PERIOD_01_MS 600
`define WDOG_PERIOD_10_MS 200
`define BROWNOUT_HOLD_TICKS (`BROWNOUT_HOLD_MS * `TICKS_PER_MS)
`define POWER_UP_HOLD_TICKS (`POWER_UP_RESET_HOLD_MS * `TICKS_PER_MS)
`define WDOG_00_TICKS (`WDOG_PERIOD_00_MS * `TICKS_PER_MS)
`define WDOG_01_TICKS (`WDOG_PERIOD_01_MS * `TICKS_PER_MS)
`define WDOG_10_TICKS (`WDOG_PERIOD_10_MS * `TICKS_PER_MS)
`define WDOG_SEL_DISABLED 2'h3
`define WDOG_SEL_RESET 2'h3
`define TICK_CNT_W 16
`define HOLD_CNT_W 15

`endif

// ---- supervisor_watchdog_reset_sva.sv ----
`timescale 1ns/100ps
module supervisor_watchdog_reset_sva (
  input wire clk,
  input wire resetn,
  input wire supplyLowRaw,
  input wire writeProtectIn,
  input wire periodWriteReq,
  input wire [1:0] periodWriteData,
  input wire busBusy,
  input wire resetOut,
  input wire resetOe,
  input wire busAbort,
  input wire busAcceptEn,
  input wire nvWriteGrant,
  input wire [1:0] watchdogPeriodSel,
  input wire resetActive
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Four samples cover the two-flop pin synchronisers
  property p_pol; resetOe == resetActive; endproperty
  a_pol: assert property (p_pol) else $error("pin enable off");
  property p_od; resetOut == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_ab; busAbort |-> busBusy ##1 resetActive; endproperty
  a_ab: assert property (p_ab) else $error("bad abort");
  property p_bo; supplyLowRaw [*4] |=> resetActive; endproperty
  a_bo: assert property (p_bo) else $error("no brownout reset");
  property p_acc; supplyLowRaw [*4] |-> !busAcceptEn && !nvWriteGrant; endproperty
  a_acc: assert property (p_acc) else $error("bus open at low supply");
  property p_nv; writeProtectIn [*4] |-> !nvWriteGrant; endproperty
  a_nv: assert property (p_nv) else $error("write under protect");
  property p_lock; writeProtectIn [*4] ##0 periodWriteReq |=> $stable(watchdogPeriodSel); endproperty
  a_lock: assert property (p_lock) else $error("period not locked");
  property p_wr;
    (!writeProtectIn && !supplyLowRaw) [*4] ##0 periodWriteReq |=>
      watchdogPeriodSel == $past(periodWriteData);
  endproperty
  a_wr: assert property (p_wr) else $error("period not stored");
  c_ab: cover property (busAbort);
  c_rel: cover property ($fell(resetActive));
  c_wr: cover property (periodWriteReq && !writeProtectIn);
endmodule // supervisor_watchdog_reset_sva
bind supervisor_watchdog_reset supervisor_watchdog_reset_sva u_sva (.*);

// ---- supervisor_watchdog_reset_test.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module supervisor_watchdog_reset_test;
  logic clk = 1'b0, resetn = 1'b0, supplyLowRaw = 1'b0, writeProtectIn = 1'b0;
  logic busTransactionDone = 1'b0, busBusy = 1'b0, periodWriteReq = 1'b0;
  logic nvWriteReq = 1'b0, nvWriteBusy = 1'b0, go = 1'b0;
  logic [1:0] periodWriteData = 2'h0;
  wire sdaIn, sclIn, resetOut, resetOe, busAbort, busAcceptEn, nvWriteGrant, resetActive;
  wire [1:0] watchdogPeriodSel;
  int num_errors = 0, cmp_count = 0;
  // Short tick keeps every hold and timeout within the run budget
  supervisor_watchdog_reset #(.RESET_ACTIVE_HIGH(0), .TICK_CYCLES(4)) dut (
    .clk, .resetn, .supplyLowRaw, .sdaIn, .sclIn, .writeProtectIn,
    .busTransactionDone, .busBusy, .periodWriteReq, .periodWriteData,
    .nvWriteReq, .nvWriteBusy, .resetOut, .resetOe, .busAbort, .busAcceptEn,
    .nvWriteGrant, .watchdogPeriodSel, .resetActive);
  bus_host_model host (.go(go), .sclLine(sclIn), .sdaLine(sdaIn));
  always #4 clk = ~clk;
  task automatic wra(input int n, input logic v);
    for (int i = 0; i < n && resetActive !== v; i++) @(negedge clk);
  endtask
  task automatic wr(input logic [1:0] d);
    periodWriteData = d;
    periodWriteReq = 1'b1;
    @(negedge clk);
    periodWriteReq = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_power;
    repeat (9900) @(negedge clk);
    `CHK(resetOe, 1'b1)
    wra(300, 1'b0);
    `CHK(resetActive, 1'b0)
    repeat (9000) @(negedge clk);
    `CHK({watchdogPeriodSel, resetActive}, 3'h6)
  endtask
  task automatic t_brown;
    busBusy = 1'b1;
    supplyLowRaw = 1'b1;
    for (int i = 0; i < 8 && busAbort !== 1'b1; i++) @(negedge clk);
    `CHK(busAbort, 1'b1)
    wr(2'h0);
    `CHK({busAcceptEn, resetActive, watchdogPeriodSel}, 4'h7)
    busBusy = 1'b0;
    supplyLowRaw = 1'b0;
    repeat (7900) @(negedge clk);
    `CHK(resetActive, 1'b1)
    wra(300, 1'b0);
    `CHK(resetActive, 1'b0)
  endtask
  task automatic t_lock;
    writeProtectIn = 1'b1;
    nvWriteReq = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(nvWriteGrant, 1'b0)
    wr(2'h2);
    `CHK(watchdogPeriodSel, 2'h3)
    writeProtectIn = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(nvWriteGrant, 1'b1)
    nvWriteBusy = 1'b1;
    @(negedge clk);
    `CHK(nvWriteGrant, 1'b0)
    nvWriteBusy = 1'b0;
    nvWriteReq = 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(2'(d));
      `CHK(watchdogPeriodSel, 2'(d))
    end
    wr(2'h2);
  endtask
  task automatic t_dog;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (5000) @(negedge clk);
    busTransactionDone = 1'b1;
    @(negedge clk);
    busTransactionDone = 1'b0;
    repeat (7800) @(negedge clk);
    `CHK(resetActive, 1'b0)
    wra(400, 1'b1);
    `CHK(resetActive, 1'b1)
    wra(8400, 1'b0);
    repeat (7800) @(negedge clk);
    `CHK(resetActive, 1'b0)
    wra(400, 1'b1);
    `CHK(resetActive, 1'b1)
  endtask
  task final_report;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(8 * 80000);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    t_power();
    t_brown();
    t_lock();
    t_dog();
    final_report();
  end
endmodule // supervisor_watchdog_reset_test
